// *** ptm_pkg.sv ***
/*
 * Package for the pulse timer: register offsets, field positions, reset values,
 * mode codes and the packed carrier structs shared by the design.
 * Assumes a 32-bit APB with word-aligned registers.
 */
`default_nettype none
package ptm_pkg;
    localparam logic [7:0] PTM_OFS_CTRL1   = 8'h00;
    localparam logic [7:0] PTM_OFS_CTRL2   = 8'h04;
    localparam logic [7:0] PTM_OFS_EVENT_CONTROL_REGISTER  = 8'h10;
    localparam logic [7:0] PTM_OFS_INTEN   = 8'h14;
    localparam logic [7:0] PTM_OFS_INTFLG  = 8'h18;
    localparam logic [7:0] PTM_OFS_STATUS  = 8'h1C;
    localparam logic [7:0] PTM_OFS_COUNT   = 8'h28;
    localparam logic [7:0] PTM_OFS_COMPARE = 8'h30;
    localparam logic [7:0] PTM_OFS_SLEEP   = 8'h40;

    localparam int PTM_BIT_ENABLE   = 0;
    localparam int PTM_BIT_CLOCK_SOURCE_SELECT   = 1;
    localparam int PTM_BIT_RESTART  = 4;
    localparam int PTM_BIT_STANDBY  = 6;
    localparam int PTM_BIT_MODE     = 0;
    localparam int PTM_BIT_OUTEN    = 4;
    localparam int PTM_BIT_INIT     = 5;
    localparam int PTM_BIT_ASYNC    = 6;
    localparam int PTM_BIT_EVIN     = 0;
    localparam int PTM_BIT_EDGE     = 4;
    localparam int PTM_BIT_FILTER   = 6;
    localparam int PTM_BIT_CAPTURE_FLAG     = 0;
    localparam int PTM_BIT_RUN      = 0;
    localparam int PTM_BIT_STBY_REQ = 0;
    localparam int PTM_BIT_PDN_REQ  = 1;

    localparam logic [7:0]  PTM_RST_CTRL  = 8'h00;
    localparam logic [15:0] PTM_RST_COUNT = 16'h0000;
    localparam logic [15:0] PTM_RST_CMP   = 16'h0000;

    localparam logic [2:0] PTM_MODE_SINGLE = 3'h6;
    localparam logic [2:0] PTM_MODE_BYTE_PWM_MODE   = 3'h7;
    localparam logic [1:0] PTM_CLK_DIV1    = 2'h0;
    localparam logic [1:0] PTM_CLK_DIV2    = 2'h1;
    localparam logic [1:0] PTM_CLK_COMP    = 2'h2;

    localparam int PTM_FILTER_TAPS = 4;
    localparam int PTM_SYNC_TAPS   = 3;

    typedef struct packed {
        logic       standby_keep_running;
        logic       companion_restart_enable;
        logic [1:0] clock_source_select;
        logic       enable;
    } ptm_ctrl_one_type;

    typedef struct packed {
        logic       async_start;
        logic       pin_initial_level;
        logic       waveform_output_enable;
        logic [2:0] timer_mode_field;
    } ptm_ctrl_two_type;

    typedef struct packed {
        logic filter_enable;
        logic edge_any;
        logic event_input_enable;
    } ptm_ev_ctrl_type;
endpackage
`default_nettype wire

// *** ptm_pulse_timer.sv ***
/*
 * Pulse timer: 16-bit counter with single-shot and 8-bit PWM waveform modes,
 * event input with noise filter, capture event, interrupt and sleep control.
 * Assumes an APB master on clk_i; event, companion tick and restart inputs
 * are asynchronous to clk_i except where noted on the port.
 */
// Design decisions made here: the placing of the registers and register access over APB.
`default_nettype none
// Function
// [RL1] Single-shot idle holds output low; event restarts counter from zero, output high.
// [RL2] At compare value counting stops, output low one tick; events then ignored.
// [RL3] Synchronous single-shot raises output two clocks after the event.
// [RL4] Edge select one starts on either edge, zero on rising only; asynchronous start takes rising edges only.
// [RL5] Enabling starts single-shot counting; software loads limit to avoid it.
// [RL6] Edge select one at enable also starts; limit load prevents it.
// [RL7] Asynchronous single-shot sets output at once; counting starts two to three ticks later; here the output waits for a two-flop synchroniser.
// [RL8] Byte PWM counts zero to low byte; set at zero, clear at high byte.
// [RL9] Byte PWM high time equals high byte; period is low byte plus one.
// [RL10] Output enable drives waveform on pin; cleared gives no output.
// [RL11] Other modes take initial output level from the pin initial bit.
// [RL12] Software avoids mode changes while enabled and clears flags after setup.
// [RL13] Filter passes a level only after four equal consecutive samples.
// [RL14] Filter adds four system clocks latency and ignores the prescaler.
// [RL15] Companion clock select advances the counter on companion ticks.
// [RL16] Restart enable restarts the counter when the companion counter restarts.
// [RL17] Capture event is a one-clock pulse under the capture flag conditions.
// [RL18] Event input enable lets events act; sender holds events one clock.
// [RL19] Asynchronous single-shot catches event edges shorter than one clock.
// [RL20] Interrupt asserted while capture enable and capture flag are both set.
// [RL21] Halt in standby unless keep-running set; always halt in power-down.
// [RL22] Status bit shows whether the single-shot counter is counting.
// [RL23] Mode code 0x6 is single-shot, 0x7 is byte PWM.
// [RL24] Clock select 0x0 full, 0x1 half, 0x2 companion clock.
// [RL25] Keep-running bit has no effect with companion clock selected.
// [RL26] Byte PWM wraps to zero after the low byte and keeps running.
module ptm_pulse_timer #(
    parameter int CNT_W = 16
) (
    input  wire logic        clk_i,
    input  wire logic        sys_rst_i,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        event_i,
    input  wire logic        companion_tick_i,
    input  wire logic        companion_restart_i,
    output logic             waveform_pin_o,
    output logic             waveform_pin_oe_o,
    output logic             capture_event_o,
    output logic             irq_o
);
    import ptm_pkg::*;

    ptm_ctrl_one_type ctrl1_q;
    ptm_ctrl_two_type ctrl2_q;
    ptm_ev_ctrl_type  evc_q;
    logic             inten_q;
    logic             capture_flag_q;
    logic             stby_q;
    logic             pdn_q;
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cmp_q;
    logic             run_q;
    logic             hold_q;
    logic             wave_q;
    logic [1:0]       start_dly_q;
    logic             div_q;
    logic             ready_q;
    logic [31:0]      rdata_q;
    logic             err_q;
    logic [PTM_SYNC_TAPS-1:0]   ev_sync_q;
    logic [PTM_SYNC_TAPS-1:0]   tick_sync_q;
    logic [PTM_SYNC_TAPS-1:0]   rst_sync_q;
    logic [PTM_FILTER_TAPS-1:0] filt_q;
    logic             ev_level_q;
    logic             tick_level_q;
    logic             rst_level_q;
    logic             ev_prev_q;
    logic             tick_prev_q;
    logic             rst_prev_q;
    logic             async_hit_q;
    logic [1:0]       async_sync_q;
    logic             async_prev_q;

    function automatic logic agree(input logic [PTM_SYNC_TAPS-1:0] s, input logic cur);
        logic r;
        r = cur;
        if (s[1] == s[2]) begin
            r = s[1];
        end
        return r;
    endfunction

    wire logic access   = psel && penable && ready_q;
    wire logic wr_en    = access && pwrite;
    wire logic rd_en    = access && !pwrite;
    wire logic sel_c1   = (paddr == PTM_OFS_CTRL1);
    wire logic sel_c2   = (paddr == PTM_OFS_CTRL2);
    wire logic sel_ev   = (paddr == PTM_OFS_EVENT_CONTROL_REGISTER);
    wire logic sel_ie   = (paddr == PTM_OFS_INTEN);
    wire logic sel_if   = (paddr == PTM_OFS_INTFLG);
    wire logic sel_st   = (paddr == PTM_OFS_STATUS);
    wire logic sel_cnt  = (paddr == PTM_OFS_COUNT);
    wire logic sel_cmp  = (paddr == PTM_OFS_COMPARE);
    wire logic sel_slp  = (paddr == PTM_OFS_SLEEP);
    wire logic mapped   = sel_c1 || sel_c2 || sel_ev || sel_ie || sel_if || sel_st
                          || sel_cnt || sel_cmp || sel_slp;

    wire logic [2:0] mode   = ctrl2_q.timer_mode_field;
    // [RL23] Mode decode.
    wire logic is_single    = (mode == PTM_MODE_SINGLE);
    wire logic is_pwm       = (mode == PTM_MODE_BYTE_PWM_MODE);
    wire logic comp_clk     = (ctrl1_q.clock_source_select == PTM_CLK_COMP);
    // [RL21] Sleep halt; [RL25] keep-running ignored on companion clock.
    wire logic halted       = pdn_q || (stby_q && (comp_clk || !ctrl1_q.standby_keep_running));
    wire logic active       = ctrl1_q.enable && !halted;
    // [RL24] Tick select; [RL15] companion ticks.
    wire logic tick_comp    = tick_level_q && !tick_prev_q;
    wire logic tick         = active && ((ctrl1_q.clock_source_select == PTM_CLK_DIV1)
                              || ((ctrl1_q.clock_source_select == PTM_CLK_DIV2) && div_q)
                              || (comp_clk && tick_comp));
    // [RL13] Filter or direct level into the edge detector.
    wire logic ev_in        = evc_q.filter_enable ? ev_level_q : ev_sync_q[2];
    wire logic ev_rise      = ev_in && !ev_prev_q;
    wire logic ev_fall      = !ev_in && ev_prev_q;
    // [RL4] Edge selection; [RL18] input enable.
    wire logic ev_edge      = evc_q.event_input_enable
                              && (ev_rise || (evc_q.edge_any && ev_fall));
    wire logic async_edge   = async_sync_q[1] && !async_prev_q;
    wire logic use_async    = is_single && ctrl2_q.async_start;
    // [RL2] Events ignored while running or during the low hold.
    wire logic trig         = active && is_single && !run_q && !hold_q
                              && (use_async ? async_edge : ev_edge);
    // [RL16] Companion restart.
    wire logic comp_rst     = active && ctrl1_q.companion_restart_enable
                              && rst_level_q && !rst_prev_q;
    wire logic at_cmp       = (cnt_q == cmp_q);
    wire logic pwm_top      = (cnt_q[7:0] == cmp_q[7:0]);
    wire logic capture_flag_set     = tick && ((is_single && run_q && at_cmp)
                              || (is_pwm && pwm_top) || (!is_single && !is_pwm && at_cmp));
    wire logic [CNT_W-1:0] cnt_inc = cnt_q + CNT_W'(1);

    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (sel_c1) begin
            rd_mux[PTM_BIT_ENABLE]      = ctrl1_q.enable;
            rd_mux[PTM_BIT_CLOCK_SOURCE_SELECT +: 2] = ctrl1_q.clock_source_select;
            rd_mux[PTM_BIT_RESTART]     = ctrl1_q.companion_restart_enable;
            rd_mux[PTM_BIT_STANDBY]     = ctrl1_q.standby_keep_running;
        end else if (sel_c2) begin
            rd_mux[PTM_BIT_MODE +: 3] = ctrl2_q.timer_mode_field;
            rd_mux[PTM_BIT_OUTEN]     = ctrl2_q.waveform_output_enable;
            rd_mux[PTM_BIT_INIT]      = ctrl2_q.pin_initial_level;
            rd_mux[PTM_BIT_ASYNC]     = ctrl2_q.async_start;
        end else if (sel_ev) begin
            rd_mux[PTM_BIT_EVIN]   = evc_q.event_input_enable;
            rd_mux[PTM_BIT_EDGE]   = evc_q.edge_any;
            rd_mux[PTM_BIT_FILTER] = evc_q.filter_enable;
        end else if (sel_ie) begin
            rd_mux[PTM_BIT_CAPTURE_FLAG] = inten_q;
        end else if (sel_if) begin
            rd_mux[PTM_BIT_CAPTURE_FLAG] = capture_flag_q;
        end else if (sel_st) begin
            // [RL22] Running status.
            rd_mux[PTM_BIT_RUN] = run_q;
        end else if (sel_cnt) begin
            rd_mux[CNT_W-1:0] = cnt_q;
        end else if (sel_cmp) begin
            rd_mux[CNT_W-1:0] = cmp_q;
        end else if (sel_slp) begin
            rd_mux[PTM_BIT_STBY_REQ] = stby_q;
            rd_mux[PTM_BIT_PDN_REQ]  = pdn_q;
        end
    end

    // APB slave: one wait state, so every access ends two cycles after setup.
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            ready_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            err_q   <= 1'b0;
        end else begin
            ready_q <= psel && penable && !ready_q;
            err_q   <= psel && penable && !ready_q && !mapped;
            if (psel && penable && !ready_q && !pwrite) begin
                rdata_q <= rd_mux;
            end
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            ctrl1_q <= '0;
            ctrl2_q <= '0;
            evc_q   <= '0;
            inten_q <= 1'b0;
            stby_q  <= 1'b0;
            pdn_q   <= 1'b0;
            cmp_q   <= PTM_RST_CMP;
        end else if (wr_en) begin
            if (sel_c1) begin
                ctrl1_q <= '{pwdata[PTM_BIT_STANDBY], pwdata[PTM_BIT_RESTART],
                             pwdata[PTM_BIT_CLOCK_SOURCE_SELECT +: 2], pwdata[PTM_BIT_ENABLE]};
            end else if (sel_c2) begin
                ctrl2_q <= '{pwdata[PTM_BIT_ASYNC], pwdata[PTM_BIT_INIT],
                             pwdata[PTM_BIT_OUTEN], pwdata[PTM_BIT_MODE +: 3]};
            end else if (sel_ev) begin
                evc_q <= '{pwdata[PTM_BIT_FILTER], pwdata[PTM_BIT_EDGE],
                           pwdata[PTM_BIT_EVIN]};
            end else if (sel_ie) begin
                inten_q <= pwdata[PTM_BIT_CAPTURE_FLAG];
            end else if (sel_cmp) begin
                cmp_q <= pwdata[CNT_W-1:0];
            end else if (sel_slp) begin
                stby_q <= pwdata[PTM_BIT_STBY_REQ];
                pdn_q  <= pwdata[PTM_BIT_PDN_REQ];
            end
        end
    end

    // Input synchronisers; only the second and third stages are compared.
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            ev_sync_q    <= '0;
            tick_sync_q  <= '0;
            rst_sync_q   <= '0;
            tick_level_q <= 1'b0;
            rst_level_q  <= 1'b0;
            tick_prev_q  <= 1'b0;
            rst_prev_q   <= 1'b0;
        end else begin
            ev_sync_q    <= {ev_sync_q[1:0], event_i};
            tick_sync_q  <= {tick_sync_q[1:0], companion_tick_i};
            rst_sync_q   <= {rst_sync_q[1:0], companion_restart_i};
            tick_level_q <= agree(tick_sync_q, tick_level_q);
            rst_level_q  <= agree(rst_sync_q, rst_level_q);
            tick_prev_q  <= tick_level_q;
            rst_prev_q   <= rst_level_q;
        end
    end

    // [RL13] Four-sample window; [RL14] runs every system clock, not on ticks.
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            filt_q     <= '0;
            ev_level_q <= 1'b0;
            ev_prev_q  <= 1'b0;
        end else begin
            filt_q    <= {filt_q[PTM_FILTER_TAPS-2:0], ev_sync_q[1]};
            ev_prev_q <= ev_in;
            if (&filt_q) begin
                ev_level_q <= 1'b1;
            end else if (~|filt_q) begin
                ev_level_q <= 1'b0;
            end
        end
    end

    // [RL19] Edge catcher clocked by the event itself, cleared once seen.
    wire logic async_clr = sys_rst_i || (async_sync_q[1] && !use_async) || async_prev_q;
    always_ff @(posedge event_i or posedge async_clr) begin
        if (async_clr) begin
            async_hit_q <= 1'b0;
        end else begin
            async_hit_q <= 1'b1;
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            async_sync_q <= 2'b00;
            async_prev_q <= 1'b0;
        end else begin
            async_sync_q <= {async_sync_q[0], async_hit_q};
            async_prev_q <= async_sync_q[1];
        end
    end

    // Counter, single-shot sequencing and capture flag.
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cnt_q       <= PTM_RST_COUNT;
            run_q       <= 1'b0;
            hold_q      <= 1'b0;
            start_dly_q <= 2'b00;
            div_q       <= 1'b0;
            capture_flag_q      <= 1'b0;
        end else begin
            div_q       <= !div_q;
            start_dly_q <= {start_dly_q[0], trig};
            // [RL20] Set wins over a write-one clear in the same cycle.
            if (capture_flag_set) begin
                capture_flag_q <= 1'b1;
            end else if (wr_en && sel_if && pwdata[PTM_BIT_CAPTURE_FLAG]) begin
                capture_flag_q <= 1'b0;
            end
            if (wr_en && sel_cnt) begin
                cnt_q <= pwdata[CNT_W-1:0];
            end else if (comp_rst) begin
                cnt_q <= PTM_RST_COUNT;
            // [RL1] Event restarts from zero; [RL3] two clocks after the event.
            end else if (start_dly_q[1] && is_single) begin
                cnt_q <= PTM_RST_COUNT;
                run_q <= 1'b1;
            end else if (tick) begin
                if (is_single) begin
                    // [RL5] [RL6] Counting runs from enable unless loaded with the limit.
                    if (at_cmp) begin
                        run_q  <= 1'b0;
                        hold_q <= run_q;
                    end else begin
                        cnt_q  <= cnt_inc;
                        hold_q <= 1'b0;
                        run_q  <= 1'b1;
                    end
                end else if (is_pwm) begin
                    // [RL26] Wrap at the low byte and keep running.
                    cnt_q <= pwm_top ? PTM_RST_COUNT : cnt_inc;
                end else begin
                    cnt_q <= at_cmp ? PTM_RST_COUNT : cnt_inc;
                end
            end
            if (!is_single || !ctrl1_q.enable) begin
                run_q  <= 1'b0;
                hold_q <= 1'b0;
            end
        end
    end

    // Waveform level; the asynchronous start still reaches the pin through a
    // synchroniser, since no output may bypass a flip-flop here.
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            wave_q <= 1'b0;
        end else if (is_single) begin
            // [RL7] Asynchronous start raises the output on the caught edge.
            wave_q <= run_q || start_dly_q[1] || (trig && use_async) ||
                      (wave_q && !hold_q && use_async);
        end else if (is_pwm) begin
            // [RL8] [RL9] High from zero until the high byte.
            if (tick) begin
                wave_q <= pwm_top ? (cmp_q[15:8] != 8'h00)
                                  : (cnt_inc[7:0] < cmp_q[15:8]);
            end
        end else if (!ctrl1_q.enable) begin
            // [RL11] Initial level for other modes.
            wave_q <= ctrl2_q.pin_initial_level;
        end else if (capture_flag_set) begin
            wave_q <= !wave_q;
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            waveform_pin_o    <= 1'b0;
            waveform_pin_oe_o <= 1'b0;
            capture_event_o   <= 1'b0;
            irq_o             <= 1'b0;
        end else begin
            // [RL10] Pin driven only with output enable.
            waveform_pin_o    <= ctrl2_q.waveform_output_enable && wave_q;
            waveform_pin_oe_o <= ctrl2_q.waveform_output_enable;
            // [RL17] One-clock capture event pulse.
            capture_event_o   <= capture_flag_set;
            // [RL20] Interrupt level.
            irq_o             <= inten_q && capture_flag_q;
        end
    end

    assign prdata  = rdata_q;
    assign pready  = ready_q;
    assign pslverr = err_q;
endmodule
`default_nettype wire

// *** ptm_pulse_timer_properties.sv ***
/* Port checker for the pulse timer.
   Assumes one clock domain and the asynchronous high reset. */
`default_nettype none
module ptm_pulse_timer_properties (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic waveform_pin_o,
    input wire logic waveform_pin_oe_o,
    input wire logic capture_event_o,
    input wire logic irq_o
);
    logic [2:0] wr_q;
    logic [2:0] capture_flag_q;
    wire  logic wr_done = psel & penable & pwrite & pready;
    // Register-driven outputs may only move shortly after a write lands.
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            wr_q <= 3'h0;
            capture_flag_q <= 3'h0;
        end else begin
            wr_q <= {wr_q[1:0], wr_done};
            capture_flag_q <= {capture_flag_q[1:0], capture_event_o};
        end
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    apb_wait_a: assert property (psel && penable && !pready |=> pready)
        else $error("pready late");
    apb_err_a: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    out_gated_a: assert property (!waveform_pin_oe_o |-> !waveform_pin_o)
        else $error("pin driven while disabled");
    oe_by_write_a: assert property ($changed(waveform_pin_oe_o) |-> wr_q != 3'h0)
        else $error("enable moved without write");
    low_gap_a: assert property ($fell(waveform_pin_o) |=> !waveform_pin_o)
        else $error("low time under one tick");
    capture_flag_single_a: assert property (capture_event_o |=> !capture_event_o)
        else $error("capture event too long");
    irq_cause_a: assert property ($rose(irq_o) |-> (capture_flag_q | wr_q) != 3'h0)
        else $error("irq rose without cause");
    irq_hold_a: assert property ($fell(irq_o) |-> wr_q != 3'h0)
        else $error("irq dropped without clear");
    cover property ($rose(irq_o));
    cover property (capture_event_o);
    cover property ($rose(waveform_pin_o) ##[1:40] $fell(waveform_pin_o));
endmodule
bind ptm_pulse_timer ptm_pulse_timer_properties i_props (.clk_i, .sys_rst_i, .psel,
    .penable, .pwrite, .pready, .pslverr, .waveform_pin_o, .waveform_pin_oe_o,
    .capture_event_o, .irq_o);
`default_nettype wire

// *** ptm_far_side.sv ***
/* Far side model: event network and companion timer.
   Assumes clk_i is the system clock of the timer. */
`default_nettype none
module ptm_far_side (
    input  wire logic clk_i,
    input  wire logic ev_req_i,
    input  wire logic comp_run_i,
    output var  logic event_o,
    output var  logic tick_o,
    output var  logic restart_o
);
    int div_q = 0;
    int cnt_q = 0;
    initial begin
        event_o = 1'b0;
        tick_o = 1'b0;
        restart_o = 1'b0;
    end
    always @(posedge clk_i) event_o <= ev_req_i;
    // Ticks stand still unless the companion runs; each tick level holds two clocks, a restart pulse four.
    always @(posedge clk_i) begin
        div_q <= (div_q + 1) % 4;
        tick_o <= comp_run_i && div_q < 2;
        if (div_q == 0) cnt_q <= (cnt_q + 1) % 8;
        restart_o <= comp_run_i && cnt_q == 7;
    end
endmodule
`default_nettype wire

// *** ptm_pulse_timer_tb_top.sv ***
/* Bench for the pulse timer: registers, byte PWM, single-shot, interrupt.
   Assumes the far side model drives the event and companion inputs. */
`default_nettype none
module ptm_pulse_timer_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import ptm_pkg::*;
    logic        clk_i = 1'b0, sys_rst_i = 1'b1, psel = 1'b0, penable = 1'b0;
    logic        pwrite = 1'b0, ev_req = 1'b0, comp_run = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd_q;
    logic        pready, pslverr, err_q, ev_w, tick_w, rst_w, wave, wave_oe, capture_flag, irq;
    integer      seed = 51;
    int          bad_count = 0, n_compared = 0, model[int], k, h, l, hi, per, lat[3];
    initial forever #10 clk_i = ~clk_i;
    ptm_pulse_timer i_dut (.clk_i, .sys_rst_i, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .event_i(ev_w), .companion_tick_i(tick_w),
        .companion_restart_i(rst_w), .waveform_pin_o(wave), .waveform_pin_oe_o(wave_oe),
        .capture_event_o(capture_flag), .irq_o(irq));
    ptm_far_side i_far (.clk_i, .ev_req_i(ev_req), .comp_run_i(comp_run), .event_o(ev_w),
        .tick_o(tick_w), .restart_o(rst_w));
    task automatic report_and_stop;
        $display("compared %0d mismatched %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [15:0] d);
        int n;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {16'h0000, d};
        @(posedge clk_i);
        penable <= 1'b1;
        for (n = 0; n < 20 && pready !== 1'b1; n++) @(posedge clk_i);
        if (n >= 20) begin
            chk("pready", 32'h1, 32'h0);
            report_and_stop();
        end
        rd_q = prdata;
        err_q = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (w) model[a] = d;
        @(posedge clk_i);
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        apb(1'b0, a, 16'h0000);
        chk("read", {16'h0000, e}, rd_q);
    endtask
    task automatic wait_on(input int s, input logic v);
        for (k = 0; (s == 0 ? wave : s == 1 ? capture_flag : irq) !== v && k < 300; k++)
            @(posedge clk_i);
        if (k >= 300) begin
            chk("wait", 32'h1, 32'h0);
            report_and_stop();
        end
    endtask
    task automatic wave_len;
        wait_on(0, 1'b0);
        wait_on(0, 1'b1);
        for (hi = 0; wave === 1'b1 && hi < 300; hi++) @(posedge clk_i);
        for (per = hi; wave !== 1'b1 && per < 300; per++) @(posedge clk_i);
    endtask
    initial begin
        repeat (100000) @(posedge clk_i);
        chk("run length", 32'h0, 32'h1);
        report_and_stop();
    end
    initial begin
        repeat (8) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        comp_run <= 1'b1;
        @(posedge clk_i);
        rd(PTM_OFS_CTRL1, {8'h00, PTM_RST_CTRL});
        apb(1'b0, 8'h3C, 16'h0000);
        chk("unmapped", 32'h1, 32'(err_q));
        // Clock codes 0, 1 and 2 give one, two and four clocks a count.
        for (int s = 0; s < 3; s++) begin
            h = 1 + {$random(seed)} % 6;
            l = h + 1 + {$random(seed)} % 4;
            apb(1'b1, PTM_OFS_CTRL1, 16'h0000);
            apb(1'b1, PTM_OFS_COMPARE, 16'(h * 256 + l));
            apb(1'b1, PTM_OFS_COUNT, 16'h0000);
            apb(1'b1, PTM_OFS_CTRL2, 16'h0010 | {13'h0000, PTM_MODE_BYTE_PWM_MODE});
            apb(1'b1, PTM_OFS_CTRL1, 16'(1 + 2 * s));
            rd(PTM_OFS_COMPARE, 16'(model[PTM_OFS_COMPARE]));
            wave_len();
            wave_len();
            chk("pwm high", 32'(h * (s + 1 + s / 2)), 32'(hi));
            chk("pwm period", 32'((l + 1) * (s + 1 + s / 2)), 32'(per));
        end
        chk("pin enable", 32'h1, 32'(wave_oe));
        apb(1'b1, PTM_OFS_CTRL1, 16'h0000);
        apb(1'b1, PTM_OFS_CTRL2, {13'h0000, PTM_MODE_SINGLE});
        repeat (4) @(posedge clk_i);
        chk("pin off", 32'h0, {30'h0, wave_oe, wave});
        apb(1'b1, PTM_OFS_COMPARE, 16'h0014);
        apb(1'b1, PTM_OFS_COUNT, 16'h0014);
        apb(1'b1, PTM_OFS_CTRL1, 16'h0001);
        rd(PTM_OFS_STATUS, 16'h0000);
        // Runs: plain, filtered, then asynchronous start.
        for (int f = 0; f < 3; f++) begin
            apb(1'b1, PTM_OFS_EVENT_CONTROL_REGISTER, f == 1 ? 16'h0041 : 16'h0001);
            apb(1'b1, PTM_OFS_CTRL2, f == 2 ? 16'h0056 : 16'h0016);
            ev_req <= 1'b0;
            repeat (12) @(posedge clk_i);
            chk("idle pin", 32'h0, 32'(wave));
            ev_req <= 1'b1;
            wait_on(0, 1'b1);
            lat[f] = k;
            rd(PTM_OFS_STATUS, 16'h0001);
            wait_on(0, 1'b0);
            chk("pulse end", 32'h1, 32'(k >= 12 && k <= 20));
        end
        chk("filter delay", 32'h4, 32'(lat[1] - lat[0]));
        chk("async lead", 32'h1, 32'(lat[2] < lat[0]));
        apb(1'b1, PTM_OFS_CTRL2, 16'h0016);
        apb(1'b1, PTM_OFS_EVENT_CONTROL_REGISTER, 16'h0011);
        ev_req <= 1'b0;
        wait_on(0, 1'b1);
        chk("falling start", 32'h1, 32'(k <= 12));
        wait_on(0, 1'b0);
        apb(1'b1, PTM_OFS_CTRL1, 16'h0000);
        apb(1'b1, PTM_OFS_CTRL2, 16'h0030);
        apb(1'b1, PTM_OFS_COMPARE, 16'h0009);
        apb(1'b1, PTM_OFS_COUNT, 16'h0000);
        apb(1'b1, PTM_OFS_INTFLG, 16'h0001);
        apb(1'b1, PTM_OFS_INTEN, 16'h0001);
        apb(1'b1, PTM_OFS_CTRL1, 16'h0001);
        chk("initial level", 32'h1, 32'(wave));
        wait_on(1, 1'b1);
        wait_on(2, 1'b1);
        chk("irq delay", 32'h1, 32'(k <= 2));
        apb(1'b1, PTM_OFS_CTRL1, 16'h0000);
        rd(PTM_OFS_INTFLG, 16'h0001);
        apb(1'b1, PTM_OFS_INTEN, 16'h0000);
        repeat (2) @(posedge clk_i);
        chk("irq masked", 32'h0, 32'(irq));
        apb(1'b1, PTM_OFS_INTEN, 16'h0001);
        repeat (2) @(posedge clk_i);
        chk("irq unmasked", 32'h1, 32'(irq));
        apb(1'b1, PTM_OFS_INTFLG, 16'h0001);
        repeat (2) @(posedge clk_i);
        chk("irq cleared", 32'h0, 32'(irq));
        rd(PTM_OFS_INTFLG, 16'h0000);
        report_and_stop();
    end
endmodule
`default_nettype wire
